// file: rtl/bc_codec.sv
// Bi-phase decoder, slip buffer and bi-phase encoder for one ring node
//
// What this block does
// - Ring traffic is one continuous serial stream at 12 Mb/s.
// - Transmitter encodes the NRZ stream into bi-phase using the 24 MHz transmit clock.
// - Receiver follows line transitions with the 24 MHz receive clock, recovering clock and data.
// - Each 83.33 ns cell is a clock window followed by a data window.
// - No clock-window transition flags a bi-phase error and yields a zero bit.
// - Data-window transition means one; none means zero, both ways.
// - Received data is forwarded to the ring, or replaced when stripping.
// - Slip buffer inserts variable delay between receive and transmit clocks.
// - Slip buffer is a circular FIFO keeping ring delay whole bits.
// - With clocks in phase the buffer delays the stream by one bit.
// - Underflow reported when the offset is half a bit or less and no re-init is requested or pending.
// - Overflow reported when the offset is one and a half bits or more and no re-init is requested or pending.
// - After underflow or overflow the ring re-initialises and resumes.
`timescale 1ns/10ps
`default_nettype none

module bc_codec
  import bc_pkg::*;
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Line side; inputs asynchronous to clk_i, tx_bp_o registered on clk_i
  input  wire logic rx_bp_i,
  input  wire logic rx_clk_i,
  input  wire logic tx_clk_i,
  output logic      tx_bp_o,
  // Node control side, on clk_i
  input  wire logic strip_i,
  input  wire logic strip_data_i,
  input  wire logic reinit_i,
  output bc_bit_t   rx_o,
  output bc_evt_t   evt_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisers and half-cell tick detection

  logic [SYNC_W-1:0] rx_clk_sync;
  logic [SYNC_W-1:0] tx_clk_sync;
  logic [1:0]        rx_bp_sync;
  logic              rx_tick;
  logic              tx_tick;
  logic              line;

  // Stage 0 feeds stage 1 only; edges are taken from stages 1 and 2
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_clk_sync <= '0;
      tx_clk_sync <= '0;
      rx_bp_sync  <= '0;
    end else begin
      rx_clk_sync <= {rx_clk_sync[SYNC_W-2:0], rx_clk_i};
      tx_clk_sync <= {tx_clk_sync[SYNC_W-2:0], tx_clk_i};
      rx_bp_sync  <= {rx_bp_sync[0], rx_bp_i};
    end
  end

  // Rising edge of each 24 MHz clock marks one half cell
  assign rx_tick = rx_clk_sync[1] & ~rx_clk_sync[2];
  assign tx_tick = tx_clk_sync[1] & ~tx_clk_sync[2];
  assign line    = rx_bp_sync[1];

  ////////////////////////////////////////////////////////////////////////////
  // Bi-phase decoder

  logic rx_half;   // 0: clock window next, 1: data window next
  logic rx_s0;     // Sample taken in the clock window
  logic rx_prev;   // Last sample of the previous cell
  logic cell_done;
  logic clk_tr;
  logic data_tr;
  logic cell_bit;

  assign cell_done = rx_tick & rx_half;
  assign clk_tr    = rx_s0 != rx_prev;
  assign data_tr   = line != rx_s0;
  assign cell_bit  = clk_tr & data_tr;

  // Window tracking; a missing clock transition slips the phase by half a cell
  // so that the decoder hunts onto the true cell boundary
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_half <= 1'b0;
      rx_s0   <= 1'b0;
      rx_prev <= 1'b0;
    end else if (rx_tick) begin
      if (!rx_half) begin
        rx_s0   <= line;
        rx_half <= 1'b1;
      end else if (!clk_tr) begin
        rx_prev <= rx_s0;
        rx_s0   <= line;
      end else begin
        rx_prev <= line;
        rx_half <= 1'b0;
      end
    end
  end

  // Recovered bit toward the node
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_o         <= '0;
    end else begin
      rx_o.valid   <= cell_done;
      rx_o.data    <= cell_done & cell_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Slip buffer

  logic             slip_buffer [SB_DEPTH];
  logic [SB_AW-1:0] wr_ptr;
  logic [SB_AW-1:0] rd_ptr;
  logic [SB_AW-1:0] next_wr_ptr;
  logic [3:0]       fill;        // Delay held, in half bits
  logic [3:0]       next_fill;
  logic             rd_cell;
  logic             store_bit;
  logic             too_low;
  logic             too_high;
  logic             recenter;
  logic             reinit_pend; // Re-init held until the next transmit cell start
  logic             reinit_any;
  logic             tx_half;
  logic             tx_bit;

  assign rd_cell     = tx_tick & ~tx_half;
  assign store_bit   = strip_i ? strip_data_i : cell_bit;
  assign next_wr_ptr = cell_done ? wr_ptr + 2'h1 : wr_ptr;

  // Fill follows both clocks: receive half ticks add, transmit half ticks remove
  always_comb begin
    next_fill = fill;
    if (rx_tick && !tx_tick && fill != 4'hF) begin
      next_fill = fill + 4'h1;
    end else if (tx_tick && !rx_tick && fill != 4'h0) begin
      next_fill = fill - 4'h1;
    end
  end

  // Offset is judged at each transmit cell start
  assign too_low  = rd_cell & (next_fill <= FILL_LOW);
  assign too_high = rd_cell & (next_fill >= FILL_HIGH);
  // Re-init waits for a transmit cell start, the only phase at which the nominal fill is right
  assign reinit_any = reinit_i | reinit_pend;
  assign recenter   = too_low | too_high | (rd_cell & reinit_any);

  // Storage written at receive cell rate; cleared so the first transmitted bits are defined
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slip_buffer <= '{default: 1'b0};
    end else if (cell_done) begin
      slip_buffer[wr_ptr] <= store_bit;
    end
  end

  // Pointers wrap; a re-centre puts read one bit behind write again
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr <= WR_RST;
      rd_ptr <= RD_RST;
      fill   <= FILL_NOM;
    end else begin
      wr_ptr <= next_wr_ptr;
      if (recenter) begin
        rd_ptr <= next_wr_ptr - 2'h1;
        fill   <= FILL_NOM;
      end else begin
        if (rd_cell) begin
          rd_ptr <= rd_ptr + 2'h1;
        end
        fill <= next_fill;
      end
    end
  end

  // Re-init request parked until the next transmit cell start
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reinit_pend <= 1'b0;
    end else if (rd_cell) begin
      reinit_pend <= 1'b0;
    end else if (reinit_i) begin
      reinit_pend <= 1'b1;
    end
  end

  // Event pulses, one cycle each; a pending re-init suppresses the slip ones
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      evt_o <= '0;
    end else begin
      evt_o.bp_err <= cell_done & ~clk_tr;
      evt_o.under  <= too_low & ~reinit_any;
      evt_o.over   <= too_high & ~reinit_any;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bi-phase encoder

  // Clock window always toggles; data window toggles for a one
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tx_half <= 1'b0;
      tx_bit  <= 1'b0;
      tx_bp_o <= 1'b0;
    end else if (tx_tick) begin
      tx_half <= ~tx_half;
      if (!tx_half) begin
        tx_bit  <= slip_buffer[rd_ptr];
        tx_bp_o <= ~tx_bp_o;
      end else if (tx_bit) begin
        tx_bp_o <= ~tx_bp_o;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  // Helper: cycles since the last receive half tick
  logic [7:0] rx_gap;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_gap <= 8'hFF;
    end else if (rx_tick) begin
      rx_gap <= 8'h0;
    end else if (rx_gap != 8'hFF) begin
      rx_gap <= rx_gap + 8'h1;
    end
  end

  sequence rx_cell_end;
    cell_done;
  endsequence

  sequence tx_cell_start;
    rd_cell;
  endsequence

  half_spacing_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rx_tick && rx_gap != 8'hFF |-> rx_gap >= 8'(HALF_CYC - 1))
    else $error("receive half ticks closer than half a cell");

  enc_clock_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tx_cell_start |=> tx_bp_o != $past(tx_bp_o))
    else $error("no clock window transition on transmit");

  enc_data_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tx_tick && tx_half |=> (tx_bp_o != $past(tx_bp_o)) == $past(tx_bit))
    else $error("data window transition does not match bit");

  dec_error_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rx_cell_end and !clk_tr |=> evt_o.bp_err && rx_o.valid && !rx_o.data)
    else $error("missing clock transition not flagged as zero");

  dec_data_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rx_cell_end and clk_tr |=> rx_o.valid && rx_o.data == $past(data_tr) && !evt_o.bp_err)
    else $error("decoded bit wrong");

  one_bit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    recenter |=> fill == FILL_NOM && wr_ptr - rd_ptr == 2'h1)
    else $error("pointers not one bit apart after re-centre");

  under_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tx_cell_start and next_fill <= FILL_LOW and !reinit_any |=> evt_o.under ##1 !evt_o.under)
    else $error("underflow not pulsed");

  over_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    tx_cell_start and next_fill >= FILL_HIGH and !reinit_any |=> evt_o.over ##1 !evt_o.over)
    else $error("overflow not pulsed");

  strip_data_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rx_cell_end and strip_i |=> slip_buffer[$past(wr_ptr)] == $past(strip_data_i))
    else $error("stripped bit not replaced");

  single_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    evt_o.bp_err |=> !evt_o.bp_err)
    else $error("bi-phase error longer than one cycle");

endmodule // bc_codec

`default_nettype wire

// file: rtl/bc_pkg.sv
// Constants and carrier types for the bi-phase codec with slip buffer
package bc_pkg;
  // Timing: system clock and line cell
  localparam int unsigned CLK_PERIOD_PS  = 5000;                       // 200 MHz system clock
  localparam int unsigned LINE_RATE_KBPS = 12000;                      // Serial line rate
  localparam int unsigned CELL_TIME_PS   = 83330;                      // One bit cell
  localparam int unsigned CELL_CYC       = CELL_TIME_PS / CLK_PERIOD_PS; // Whole cycles per cell, rounds down
  localparam int unsigned HALF_CYC       = CELL_CYC / 2;               // Least spacing of half-cell ticks

  // Synchroniser depth plus one edge-history stage
  localparam int unsigned SYNC_W = 3;

  // Slip buffer geometry and fill thresholds, counted in half bits
  localparam int unsigned      SB_DEPTH  = 4;
  localparam int unsigned      SB_AW     = 2;
  localparam logic [SB_AW-1:0] WR_RST    = 2'h1;                       // Write leads read by one bit
  localparam logic [SB_AW-1:0] RD_RST    = 2'h0;
  localparam logic [3:0]       FILL_NOM  = 4'h2;                       // One bit of delay
  localparam logic [3:0]       FILL_LOW  = 4'h1;                       // Half a bit or less
  localparam logic [3:0]       FILL_HIGH = 4'h3;                       // One and a half bits or more

  // Recovered bit toward the node
  typedef struct packed {
    logic data;
    logic valid;
  } bc_bit_t;

  // Single-cycle event indications
  typedef struct packed {
    logic bp_err;
    logic under;
    logic over;
  } bc_evt_t;
endpackage

// file: tb/bc_ring_peer.sv
// Behavioural neighbour nodes: bi-phase source and transmit clock
`timescale 1ns/10ps
`default_nettype none

module bc_ring_peer (
  // From the bench
  input  wire logic [7:0] pat_i,
  input  wire logic       bad_i,
  input  wire logic [7:0] tx_half_i,
  // Toward the block and the bench
  output logic            rx_clk_o,
  output logic            rx_bp_o,
  output logic            tx_clk_o,
  output logic            cur_o,
  output logic            cur_bad_o
);
  logic       ph;
  logic [2:0] idx;

  ////////////////////////////////////////////////////////////
  // Line moves at falling edges so the block samples mid-half
  initial begin
    {rx_clk_o, rx_bp_o, cur_o, cur_bad_o, ph, idx} = '0;
    forever begin
      #32 rx_clk_o = 1'b1;
      #32 rx_clk_o = 1'b0;
      ph = ~ph;
      if (ph) begin
        cur_o = pat_i[idx];
        cur_bad_o = bad_i;
        idx = idx + 3'h1;
        rx_bp_o = rx_bp_o ^ ~bad_i;
      end else begin
        rx_bp_o = rx_bp_o ^ cur_o;
      end
    end
  end

  ////////////////////////////////////////////////////////////
  // Rate set by the bench to push the buffer off centre
  initial begin
    tx_clk_o = 1'b0;
    #17;
    forever #(tx_half_i) tx_clk_o = ~tx_clk_o;
  end
endmodule // bc_ring_peer
`default_nettype wire

// file: tb/bc_codec_tb_top.sv
// Self-checking bench for the bi-phase codec with slip buffer
`timescale 1ns/10ps
`default_nettype none

module bc_codec_tb_top
  import bc_pkg::*;
;
  logic       clk, rst_n, strip, strip_data, reinit, bad, tx_chk, tx_prev, tx_win;
  logic       rx_clk, rx_bp, tx_clk, tx_bp, cur, cur_bad;
  logic [7:0] pat, tx_half, tx_hist;
  bc_bit_t    rx;
  bc_evt_t    evt, evt_q;
  int         error_cnt, tests_run, cyc, n_under, n_over;

  bc_codec uut (.clk_i(clk), .rst_n_i(rst_n), .rx_bp_i(rx_bp), .rx_clk_i(rx_clk), .tx_clk_i(tx_clk),
    .tx_bp_o(tx_bp), .strip_i(strip), .strip_data_i(strip_data), .reinit_i(reinit), .rx_o(rx), .evt_o(evt));
  bc_ring_peer peer (.pat_i(pat), .bad_i(bad), .tx_half_i(tx_half), .rx_clk_o(rx_clk), .rx_bp_o(rx_bp),
    .tx_clk_o(tx_clk), .cur_o(cur), .cur_bad_o(cur_bad));

  // System clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////
  task automatic check(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %b, wanted %b", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Bounded wait for the next decoded cell
  task automatic wait_cell();
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (rx.valid !== 1'b1 && i < 200);
    check(rx.valid, 1'b1);
  endtask

  // Circular pattern seen from any starting cell
  function automatic logic rot_ok(input logic [7:0] h);
    logic [15:0] pp;
    rot_ok = 1'b0;
    pp = {pat, pat};
    for (int r = 0; r < 8; r++) if (pp[r +: 8] === h) rot_ok = 1'b1;
  endfunction

  ////////////////////////////////////////////////////////////
  // Events are single pulses; hang guard
  always @(posedge clk) begin
    evt_q <= evt;
    if (evt.bp_err === 1'b1) check(evt_q.bp_err, 1'b0);
    if (evt.under === 1'b1) begin
      n_under++;
      check(evt_q.under, 1'b0);
    end
    if (evt.over === 1'b1) begin
      n_over++;
      check(evt_q.over, 1'b0);
    end
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      end_of_test();
    end
  end

  // Downstream side: clock window must toggle, data window carries the bit
  always @(negedge tx_clk) begin
    if (tx_chk === 1'b1) begin
      if (tx_win) check(tx_bp !== tx_prev, 1'b1);
      else tx_hist <= {tx_bp ^ tx_prev, tx_hist[7:1]};
    end
    tx_prev <= tx_bp;
  end
  always @(posedge tx_clk) if (rst_n === 1'b1) tx_win <= ~tx_win;

  ////////////////////////////////////////////////////////////
  // Steady stream after hunting, equal rates give no slips
  task automatic t_decode();
    repeat (40) wait_cell();
    n_under = 0;
    n_over = 0;
    repeat (16) begin
      wait_cell();
      check(rx.data, cur);
      check(evt.bp_err, 1'b0);
    end
    check(n_under == 0 && n_over == 0, 1'b1);
  endtask

  // Forwarding, both stripping values, then re-init keeps the flow
  task automatic t_tx();
    tx_chk <= 1'b1;
    repeat (12) wait_cell();
    check(rot_ok(tx_hist), 1'b1);
    strip <= 1'b1;
    for (int b = 0; b < 2; b++) begin
      strip_data <= b[0];
      repeat (12) wait_cell();
      check(tx_hist === {8{b[0]}}, 1'b1);
    end
    strip <= 1'b0;
    reinit <= 1'b1;
    @(posedge clk);
    reinit <= 1'b0;
    repeat (12) wait_cell();
    check(rot_ok(tx_hist), 1'b1);
    check(n_under == 0 && n_over == 0, 1'b1);
  endtask

  // One cell without clock transition, then recovery
  task automatic t_bperr();
    bad <= 1'b1;
    wait_cell();
    bad <= 1'b0;
    check(cur_bad, 1'b1);
    check(evt.bp_err, 1'b1);
    check(rx.data, 1'b0);
    repeat (40) wait_cell();
    check(rx.data, cur);
  endtask

  // Transmit clock fast then slow
  task automatic t_slip();
    for (int s = 0; s < 2; s++) begin
      n_under = 0;
      n_over = 0;
      tx_half <= s ? 8'h22 : 8'h1E;
      repeat (8000) @(posedge clk);
      check(n_under > 0, s == 0);
      check(n_over > 0, s == 1);
    end
  endtask

  ////////////////////////////////////////////////////////////
  // Reset released while the transmit clock is low
  initial begin
    {rst_n, strip, strip_data, reinit, bad, tx_chk, tx_win} = '0;
    pat = 8'hB4;
    tx_half = 8'h20;
    repeat (8) @(posedge clk);
    @(negedge tx_clk);
    @(posedge clk);
    rst_n <= 1'b1;
    t_decode();
    t_tx();
    t_bperr();
    t_slip();
    end_of_test();
  end
endmodule // bc_codec_tb_top
`default_nettype wire
